//--- hw/adc_calibration_sequencer.sv
// Overview of operation
// - foreground cal: cores offline, outputs mid-code
// - six banks, three cores, two-way interleaved
// - dual maps A/B; single shares input
// - background swaps spare core C into service
// - foreground cal after power-up; host waits
// - trigger from pin or software bit
// - calibrate spare, hand over, rotate forever
// - low-power powers down the spare except while it wakes or calibrates
// - sleep delay times automatic spare wake
// - settle delay before calibrating woken core
// - manual swap select: automatic or triggered, low-power only
// - foreground offset cal runs once
// - background offset cal runs every rotation
// - offset cal owns offset trim registers
// - inputs stay connected during calibration
// - trims reset to factory values, read-write
`timescale 1ns/1ps
`include "cal_seq_params.svh"
module adc_calibration_sequencer #(
	parameter logic [11:0] FACTORY_OFS_A  = 12'h000,
	parameter logic [11:0] FACTORY_OFS_B  = 12'h000,
	parameter logic [11:0] FACTORY_GAIN   = 12'h800,
	parameter logic [11:0] FACTORY_TIMING = 12'h800,
	parameter logic [11:0] FACTORY_TERM   = 12'h800
) (
	// clock and reset
	input  wire logic                   sys_clk,
	input  wire logic                   reset_n,
	// apb slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [7:0]             paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	// converter side
	input  wire logic                   calibration_trigger_pin,
	input  wire cal_seq_pkg::bank_bus_t bank_samples,
	input  wire logic [11:0]            offset_estimate_a,
	input  wire logic [11:0]            offset_estimate_b,
	output logic      [11:0]            sample_a,
	output logic      [11:0]            sample_b,
	output cal_seq_pkg::core_ctl_s      core_ctl,
	output logic                        offset_calibration,
	output logic                        foreground_done_flag
);

	// ****************************************
	// functions
	// ****************************************

	// one-hot of a core index
	function automatic logic [2:0] core_bit(input logic [1:0] idx);
		core_bit = 3'h0;
		core_bit[idx] = 1'b1;
	endfunction

	// bank of a core on the given phase
	function automatic logic [11:0] bank_pick(input cal_seq_pkg::bank_bus_t bus, input logic [1:0] core,
		input logic ph);
		bank_pick = bus[{core, ph}];
	endfunction

	// delay field scaled to cycles
	function automatic logic [16:0] scaled(input logic [7:0] val, input int unit);
		scaled = 17'(val * unit);
	endfunction

	// ****************************************
	// state
	// ****************************************

	cal_seq_pkg::cal_state_e state_q;       // sequencer state
	cal_seq_pkg::ctrl_s      ctrl_q;        // control bits
	logic [15:0]             delay_q;       // wake[15:8], sleep[7:0]
	logic [16:0]             cnt_q;         // state timer
	logic [1:0]              slot_a_q;      // core serving slot a
	logic [1:0]              slot_b_q;      // core serving slot b
	logic [1:0]              spare_q;       // spare core
	logic                    swap_b_q;      // next swap targets slot b
	logic                    phase_q;       // bank phase
	logic                    trig_lvl_q;    // last trigger level
	logic [11:0]             ofs_a_q;       // offset trim, input a
	logic [11:0]             ofs_b_q;       // offset trim, input b
	logic [11:0]             gain_q;        // gain trim
	logic [11:0]             timing_q;      // interleave timing trim
	logic [11:0]             term_q;        // termination trim
	logic                    trig_lvl;      // selected trigger level
	logic                    trig_evt;      // trigger rising edge
	logic                    fg_state;      // foreground states
	logic                    spare_up;      // spare awake phase
	logic                    wr_fire;       // apb write accepted
	logic                    rd_hit;        // address decodes
	logic [31:0]             rd_data;       // read mux
	logic                    os_end;        // offset pass completes
	logic                    os_to_b;       // offset pass trims input b

	// ****************************************
	// trigger
	// ****************************************

	// pick pin or software bit
	assign trig_lvl = ctrl_q.trigger_source_select ? calibration_trigger_pin
		: ctrl_q.software_calibration_trigger;
	assign trig_evt = trig_lvl & ~trig_lvl_q;
	assign fg_state = (state_q == cal_seq_pkg::st_fg_cal) | (state_q == cal_seq_pkg::st_fg_os);
	assign spare_up = (state_q == cal_seq_pkg::st_bg_wake) | (state_q == cal_seq_pkg::st_bg_cal)
		| (state_q == cal_seq_pkg::st_bg_os);
	assign os_end = ((state_q == cal_seq_pkg::st_fg_os) | (state_q == cal_seq_pkg::st_bg_os))
		& (cnt_q == 17'h00000);
	assign os_to_b = ctrl_q.single_channel ? ctrl_q.single_input_b : swap_b_q;

	// edge history
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			trig_lvl_q <= 1'b0;
		else
			trig_lvl_q <= trig_lvl;
	end

	// ****************************************
	// sequencer
	// ****************************************

	// state and timer
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			state_q <= cal_seq_pkg::st_fg_cal;
			cnt_q   <= 17'(`CS_CAL_CYC - 1);
		end
		else
		begin
			if (cnt_q != 17'h00000)
				cnt_q <= cnt_q - 17'h00001;
			unique case (state_q)
				// foreground core calibration
				cal_seq_pkg::st_fg_cal:
				if (cnt_q == 17'h00000)
				begin
					if (ctrl_q.foreground_offset_enable)
					begin
						state_q <= cal_seq_pkg::st_fg_os;
						cnt_q   <= 17'(`CS_OS_CYC - 1);
					end
					else
						state_q <= cal_seq_pkg::st_run;
				end
				// one offset pass
				cal_seq_pkg::st_fg_os:
				if (cnt_q == 17'h00000)
					state_q <= cal_seq_pkg::st_run;
				// normal conversion
				cal_seq_pkg::st_run:
				if (trig_evt)
				begin
					if (!ctrl_q.background_calibration_enable)
					begin
						state_q <= cal_seq_pkg::st_fg_cal;
						cnt_q   <= 17'(`CS_CAL_CYC - 1);
					end
					else if (ctrl_q.low_power_background_enable)
					begin
						state_q <= cal_seq_pkg::st_bg_sleep;
						cnt_q   <= scaled(delay_q[7:0], `CS_SLEEP_UNIT);
					end
					else
					begin
						state_q <= cal_seq_pkg::st_bg_cal;
						cnt_q   <= 17'(`CS_CAL_CYC - 1);
					end
				end
				// spare asleep
				cal_seq_pkg::st_bg_sleep:
				if (ctrl_q.manual_swap_select ? trig_evt : (cnt_q == 17'h00000))
				begin
					state_q <= cal_seq_pkg::st_bg_wake;
					cnt_q   <= scaled(delay_q[15:8], `CS_WAKE_UNIT);
				end
				// spare settling
				cal_seq_pkg::st_bg_wake:
				if (cnt_q == 17'h00000)
				begin
					state_q <= cal_seq_pkg::st_bg_cal;
					cnt_q   <= 17'(`CS_CAL_CYC - 1);
				end
				// spare calibrating
				cal_seq_pkg::st_bg_cal:
				if (cnt_q == 17'h00000)
				begin
					if (ctrl_q.background_offset_enable)
					begin
						state_q <= cal_seq_pkg::st_bg_os;
						cnt_q   <= 17'(`CS_OS_CYC - 1);
					end
					else
						state_q <= cal_seq_pkg::st_bg_swap;
				end
				// background offset pass
				cal_seq_pkg::st_bg_os:
				if (cnt_q == 17'h00000)
					state_q <= cal_seq_pkg::st_bg_swap;
				// hand over, keep rotating
				cal_seq_pkg::st_bg_swap:
				if (!ctrl_q.background_calibration_enable)
					state_q <= cal_seq_pkg::st_run;
				else if (ctrl_q.low_power_background_enable)
				begin
					state_q <= cal_seq_pkg::st_bg_sleep;
					cnt_q   <= scaled(delay_q[7:0], `CS_SLEEP_UNIT);
				end
				else
				begin
					state_q <= cal_seq_pkg::st_bg_cal;
					cnt_q   <= 17'(`CS_CAL_CYC - 1);
				end
			endcase
		end
	end

	// core rotation
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			slot_a_q <= 2'h0;
			slot_b_q <= 2'h1;
			spare_q  <= 2'h2;
			swap_b_q <= 1'b0;
		end
		else if (state_q == cal_seq_pkg::st_bg_swap)
		begin
			swap_b_q <= ~swap_b_q;
			if (swap_b_q)
			begin
				slot_b_q <= spare_q;
				spare_q  <= slot_b_q;
			end
			else
			begin
				slot_a_q <= spare_q;
				spare_q  <= slot_a_q;
			end
		end
	end

	// done flag
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			foreground_done_flag <= 1'b0;
		else if (fg_state & (cnt_q == 17'h00000)
			& ~((state_q == cal_seq_pkg::st_fg_cal) & ctrl_q.foreground_offset_enable))
			foreground_done_flag <= 1'b1;
		else if ((state_q == cal_seq_pkg::st_run) & trig_evt & ~ctrl_q.background_calibration_enable)
			foreground_done_flag <= 1'b0;
	end

	// ****************************************
	// converter side outputs
	// ****************************************

	// banks and samples
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			phase_q  <= 1'b0;
			sample_a <= `CS_MID_CODE;
			sample_b <= `CS_MID_CODE;
		end
		else
		begin
			phase_q <= ~phase_q;
			if (fg_state)
			begin
				sample_a <= `CS_MID_CODE;
				sample_b <= `CS_MID_CODE;
			end
			else
			begin
				sample_a <= bank_pick(bank_samples, slot_a_q, phase_q);
				sample_b <= bank_pick(bank_samples, slot_b_q, phase_q);
			end
		end
	end

	// core controls
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			core_ctl           <= '0;
			offset_calibration <= 1'b0;
		end
		else
		begin
			core_ctl.online <= fg_state ? 3'h0 : (core_bit(slot_a_q) | core_bit(slot_b_q));
			core_ctl.power  <= (!ctrl_q.low_power_background_enable | fg_state | spare_up)
				? 3'h7 : (core_bit(slot_a_q) | core_bit(slot_b_q));
			core_ctl.calibrate <= fg_state ? 3'h7
				: ((state_q == cal_seq_pkg::st_bg_cal) | (state_q == cal_seq_pkg::st_bg_os))
				? core_bit(spare_q) : 3'h0;
			// inputs never muted here
			if (ctrl_q.single_channel)
				core_ctl.input_b <= {3{ctrl_q.single_input_b}};
			else
				core_ctl.input_b <= core_bit(slot_b_q) | (swap_b_q ? core_bit(spare_q) : 3'h0);
			offset_calibration <= (state_q == cal_seq_pkg::st_fg_os) | (state_q == cal_seq_pkg::st_bg_os);
		end
	end

	// ****************************************
	// registers
	// ****************************************

	assign wr_fire = psel & penable & pready & pwrite;

	// read mux
	always_comb
	begin
		rd_hit  = 1'b1;
		rd_data = 32'h00000000;
		unique case (paddr)
			`CS_OFF_CTRL:   rd_data = 32'(ctrl_q);
			`CS_OFF_DELAY:  rd_data = 32'(delay_q);
			`CS_OFF_STATUS: rd_data = {15'h0000, state_q, swap_b_q, spare_q, slot_b_q, slot_a_q,
				offset_calibration, foreground_done_flag};
			`CS_OFF_OFS_A:  rd_data = 32'(ofs_a_q);
			`CS_OFF_OFS_B:  rd_data = 32'(ofs_b_q);
			`CS_OFF_GAIN:   rd_data = 32'(gain_q);
			`CS_OFF_TIMING: rd_data = 32'(timing_q);
			`CS_OFF_TERM:   rd_data = 32'(term_q);
			default:        rd_hit = 1'b0;
		endcase
	end

	// apb answer, one wait state
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end
		else
		begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~rd_hit;
			prdata  <= (psel & penable & ~pready & ~pwrite) ? rd_data : 32'h00000000;
		end
	end

	// control and delays
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			ctrl_q  <= `CS_CTRL_RST;
			delay_q <= `CS_DELAY_RST;
		end
		else if (wr_fire & (paddr == `CS_OFF_CTRL))
			ctrl_q <= pwdata[8:0];
		else if (wr_fire & (paddr == `CS_OFF_DELAY))
			delay_q <= pwdata[15:0];
	end

	// trims: factory reset, offset pass wins
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			ofs_a_q  <= FACTORY_OFS_A;
			ofs_b_q  <= FACTORY_OFS_B;
			gain_q   <= FACTORY_GAIN;
			timing_q <= FACTORY_TIMING;
			term_q   <= FACTORY_TERM;
		end
		else
		begin
			if (os_end & ((state_q == cal_seq_pkg::st_fg_os) | !os_to_b))
				ofs_a_q <= offset_estimate_a;
			else if (wr_fire & (paddr == `CS_OFF_OFS_A))
				ofs_a_q <= pwdata[11:0];
			if (os_end & ((state_q == cal_seq_pkg::st_fg_os) | os_to_b))
				ofs_b_q <= offset_estimate_b;
			else if (wr_fire & (paddr == `CS_OFF_OFS_B))
				ofs_b_q <= pwdata[11:0];
			if (wr_fire & (paddr == `CS_OFF_GAIN))
				gain_q <= pwdata[11:0];
			if (wr_fire & (paddr == `CS_OFF_TIMING))
				timing_q <= pwdata[11:0];
			if (wr_fire & (paddr == `CS_OFF_TERM))
				term_q <= pwdata[11:0];
		end
	end

	// ****************************************
	// assertions
	// ****************************************

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	a_fg_mid_code: assert property (fg_state |=> (sample_a == 12'h000) && (sample_b == 12'h000))
		else $error("samples not mid-code in foreground");
	a_fg_offline: assert property (fg_state |=> core_ctl.online == 3'h0)
		else $error("core online in foreground");
	a_powerup_fg: assert property ($rose(reset_n) |-> state_q == cal_seq_pkg::st_fg_cal)
		else $error("no foreground after reset");
	a_trig_start: assert property ((state_q == cal_seq_pkg::st_run) && trig_evt
		&& !ctrl_q.background_calibration_enable |=> fg_state && !foreground_done_flag)
		else $error("trigger did not start foreground");
	a_done_rise: assert property ($rose(foreground_done_flag) |-> $past(fg_state))
		else $error("done set outside foreground");
	a_swap_handover: assert property ((state_q == cal_seq_pkg::st_bg_swap)
		|=> (slot_a_q == $past(spare_q)) || (slot_b_q == $past(spare_q)))
		else $error("spare not handed over");
	a_sleep_power: assert property ((state_q == cal_seq_pkg::st_bg_sleep)
		&& ctrl_q.low_power_background_enable |=> core_ctl.power[spare_q] == 1'b0)
		else $error("sleeping spare powered");
	a_manual_hold: assert property ((state_q == cal_seq_pkg::st_bg_sleep) && ctrl_q.manual_swap_select
		&& !trig_evt |=> state_q == cal_seq_pkg::st_bg_sleep)
		else $error("manual swap left sleep");
	a_wake_settle: assert property ($rose(state_q == cal_seq_pkg::st_bg_cal) && $past(state_q
		== cal_seq_pkg::st_bg_wake) |-> $past(cnt_q) == 17'h00000)
		else $error("settle cut short");
	a_fg_os_trim: assert property (os_end && (state_q == cal_seq_pkg::st_fg_os)
		|=> ofs_a_q == $past(offset_estimate_a))
		else $error("offset trim not written");

	c_foreground_done_flag: cover property ($rose(foreground_done_flag));
	c_bg_swap: cover property (state_q == cal_seq_pkg::st_bg_swap);
	c_lp_wake: cover property ((state_q == cal_seq_pkg::st_bg_sleep) ##1 (state_q == cal_seq_pkg::st_bg_wake));
	c_fg_os: cover property (state_q == cal_seq_pkg::st_fg_os);

endmodule // adc_calibration_sequencer

//--- hw/cal_seq_params.svh
`ifndef CAL_SEQ_PARAMS_SVH
`define CAL_SEQ_PARAMS_SVH
// register byte offsets
`define CS_OFF_CTRL    8'h00
`define CS_OFF_DELAY   8'h04
`define CS_OFF_STATUS  8'h08
`define CS_OFF_OFS_A   8'h0C
`define CS_OFF_OFS_B   8'h10
`define CS_OFF_GAIN    8'h14
`define CS_OFF_TIMING  8'h18
`define CS_OFF_TERM    8'h1C
// reset values
`define CS_CTRL_RST    9'h000
`define CS_DELAY_RST   16'h0101
`define CS_MID_CODE    12'h000
// timing
`define CS_CLK_NS      25
`define CS_CAL_NS      25600
`define CS_OS_NS       51200
`define CS_SLEEP_NS    6400
`define CS_WAKE_NS     1600
`define CS_CAL_CYC     (`CS_CAL_NS / `CS_CLK_NS)
`define CS_OS_CYC      (`CS_OS_NS / `CS_CLK_NS)
`define CS_SLEEP_UNIT  (`CS_SLEEP_NS / `CS_CLK_NS)
`define CS_WAKE_UNIT   (`CS_WAKE_NS / `CS_CLK_NS)
`endif

//--- hw/cal_seq_pkg.sv
package cal_seq_pkg;
	// sequencer states, one-hot
	typedef enum logic [7:0] {
		st_fg_cal   = 8'h01,
		st_fg_os    = 8'h02,
		st_run      = 8'h04,
		st_bg_sleep = 8'h08,
		st_bg_wake  = 8'h10,
		st_bg_cal   = 8'h20,
		st_bg_os    = 8'h40,
		st_bg_swap  = 8'h80
	} cal_state_e;
	// control register layout, bit 0 lowest
	typedef struct packed {
		logic single_input_b;
		logic single_channel;
		logic trigger_source_select;
		logic background_offset_enable;
		logic foreground_offset_enable;
		logic manual_swap_select;
		logic low_power_background_enable;
		logic background_calibration_enable;
		logic software_calibration_trigger;
	} ctrl_s;
	// per-core analog controls
	typedef struct packed {
		logic [2:0] online;
		logic [2:0] power;
		logic [2:0] calibrate;
		logic [2:0] input_b;
	} core_ctl_s;
	typedef logic [5:0][11:0] bank_bus_t;
endpackage

//--- verification/converter_model.sv
`timescale 1ns/1ps
// ****************
// converter front end
// ****************
module converter_model #(
	parameter logic [11:0] EST_A = 12'h0A5,
	parameter logic [11:0] EST_B = 12'h15A
) (
	// clock
	input  wire logic              sys_clk,
	// converter outputs
	output cal_seq_pkg::bank_bus_t bank_samples,
	output logic      [11:0]       offset_estimate_a,
	output logic      [11:0]       offset_estimate_b
);
	logic [7:0] ramp;	// running ramp shared by all banks
	initial ramp = 8'h00;
	// ramp advances every cycle
	always @(posedge sys_clk)
		ramp <= ramp + 8'h01;
	// top nibble names the bank, so a sample is never mid-code
	always_comb
		for (int i = 0; i < 6; i++)
			bank_samples[i] = {4'(i + 1), ramp};
	// quiet inputs, no content near dc, steady estimates
	assign offset_estimate_a = EST_A;
	assign offset_estimate_b = EST_B;
endmodule // converter_model

//--- verification/adc_calibration_sequencer_tb.sv
`timescale 1ns/1ps
`include "cal_seq_params.svh"
// ****************
// bench top
// ****************
module adc_calibration_sequencer_tb;
	logic                   sys_clk, reset_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0]             paddr;
	logic [31:0]            pwdata, prdata;
	logic                   calibration_trigger_pin, offset_calibration, foreground_done_flag;
	cal_seq_pkg::bank_bus_t bank_samples;
	logic [11:0]            offset_estimate_a, offset_estimate_b, sample_a, sample_b;
	cal_seq_pkg::core_ctl_s core_ctl;
	logic [31:0]            mdl [8];	// register model by word index
	logic [31:0]            rd;
	logic                   err;
	logic [3:0]             seen;
	int                     num_errors, cmp_count, cycles, zeros;

	// 40 MHz clock
	initial sys_clk = 1'b0;
	always #12.5 sys_clk = ~sys_clk;

	adc_calibration_sequencer #(
		.FACTORY_OFS_A  (12'h111),
		.FACTORY_OFS_B  (12'h222),
		.FACTORY_GAIN   (12'h333),
		.FACTORY_TIMING (12'h444),
		.FACTORY_TERM   (12'h555)
	) adc_calibration_sequencer_inst (
		.sys_clk (sys_clk), .reset_n (reset_n), .psel (psel), .penable (penable),
		.pwrite (pwrite), .paddr (paddr), .pwdata (pwdata), .prdata (prdata),
		.pready (pready), .pslverr (pslverr), .calibration_trigger_pin (calibration_trigger_pin),
		.bank_samples (bank_samples), .offset_estimate_a (offset_estimate_a),
		.offset_estimate_b (offset_estimate_b), .sample_a (sample_a), .sample_b (sample_b),
		.core_ctl (core_ctl), .offset_calibration (offset_calibration),
		.foreground_done_flag (foreground_done_flag)
	);

	converter_model converter_model_inst (
		.sys_clk (sys_clk), .bank_samples (bank_samples),
		.offset_estimate_a (offset_estimate_a), .offset_estimate_b (offset_estimate_b)
	);

	// ****************
	// checking and closing
	// ****************
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, got, exp);
		end
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// hang guard
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			num_errors++;
			stop_test();
		end
	end

	// ****************
	// apb master
	// ****************
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	// write and mirror into the model, masked to the field width
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		mdl[a[4:2]] = d & (a == `CS_OFF_CTRL ? 32'h1FF : a == `CS_OFF_DELAY ? 32'hFFFF : 32'hFFF);
	endtask

	task automatic rd_chk(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
		check(rd, mdl[a[4:2]]);
	endtask

	// one foreground pass: outputs parked, done timed
	task automatic fg_run(input int exp);
		int n;
		logic os;
		n = 0;
		os = 1'b0;
		repeat (3) @(posedge sys_clk);
		check(foreground_done_flag, 1'b0);
		check({sample_a, sample_b}, {`CS_MID_CODE, `CS_MID_CODE});
		check(core_ctl.online, 3'h0);
		check(core_ctl.calibrate, 3'h7);
		while (foreground_done_flag !== 1'b1 && n < exp + 16)
		begin
			@(posedge sys_clk);
			os |= offset_calibration;
			n++;
		end
		check(n > exp - 16 && n <= exp, 1'b1);
		check(os, exp > 1024);
	endtask

	// background watch: stream, rotation, sleep, core count
	task automatic watch(input int cyc);
		zeros = 0;
		seen = 4'h0;
		repeat (cyc)
		begin
			@(posedge sys_clk);
			zeros += (sample_a === 12'h000 || sample_b === 12'h000);
			seen[0] |= core_ctl.online[2];
			seen[1] |= offset_calibration;
			seen[2] |= |(~core_ctl.power & ~core_ctl.online);
			seen[3] |= ($countones(core_ctl.online) != 2) | (|(core_ctl.calibrate & core_ctl.online));
		end
	endtask

	// ****************
	// main sequence
	// ****************
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, calibration_trigger_pin} = '0;
		reset_n = 1'b0;
		num_errors = 0;
		cmp_count = 0;
		cycles = 0;
		mdl = '{32'h0, 32'h0101, 32'h0, 32'h111, 32'h222, 32'h333, 32'h444, 32'h555};
		void'($urandom(32'h8126));
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'b1;
		fg_run(1024);
		// host waited for done before any access
		for (int i = 0; i < 8; i++)
			if (i != 2)
				rd_chk(8'(i * 4));
		apb(1'b0, 8'h20, 32'h0);
		check(err, 1'b1);
		check(rd, 32'h0);
		apb(1'b1, 8'h24, 32'hFFFF);
		check(err, 1'b1);
		// host trims after foreground done, in normal conversion
		for (int i = 5; i < 8; i++)
		begin
			wr_reg(8'(i * 4), $urandom);
			rd_chk(8'(i * 4));
		end
		apb(1'b0, `CS_OFF_STATUS, 32'h0);
		check(rd[0], 1'b1);
		check({(sample_a[11:8] - 4'h1) >> 1, (sample_b[11:8] - 4'h1) >> 1}, 8'h01);
		check(core_ctl.input_b[1:0], 2'b10);
		wr_reg(`CS_OFF_CTRL, 32'h080);
		repeat (4) @(posedge sys_clk);
		check(core_ctl.input_b[1:0], 2'b00);
		// single channel on input b: every core takes input b
		wr_reg(`CS_OFF_CTRL, 32'h180);
		repeat (4) @(posedge sys_clk);
		check(core_ctl.input_b, 3'h7);
		// offset enable set before the trigger
		wr_reg(`CS_OFF_CTRL, 32'h010);
		wr_reg(`CS_OFF_CTRL, 32'h011);
		wr_reg(`CS_OFF_CTRL, 32'h010);
		fg_run(3072);
		mdl[3] = 32'h0A5;
		mdl[4] = 32'h15A;
		// trims read only after done
		rd_chk(`CS_OFF_OFS_A);
		rd_chk(`CS_OFF_OFS_B);
		// pin ignored while software source selected
		calibration_trigger_pin <= 1'b1;
		repeat (5) @(posedge sys_clk);
		check(foreground_done_flag, 1'b1);
		calibration_trigger_pin <= 1'b0;
		wr_reg(`CS_OFF_CTRL, 32'h040);
		calibration_trigger_pin <= 1'b1;
		fg_run(1024);
		calibration_trigger_pin <= 1'b0;
		// background with offset tracking, software source
		wr_reg(`CS_OFF_CTRL, 32'h023);
		wr_reg(`CS_OFF_CTRL, 32'h022);
		watch(7000);
		check(zeros, 0);
		check(seen, 4'b0011);
		// low-power background, automatic swaps, dual channel
		wr_reg(`CS_OFF_CTRL, 32'h007);
		wr_reg(`CS_OFF_CTRL, 32'h006);
		watch(8000);
		check(zeros, 0);
		check({seen[3:2], seen[0]}, 3'b011);
		// manual swaps: spare sleeps until a trigger wakes it
		wr_reg(`CS_OFF_CTRL, 32'h00E);
		repeat (1500) @(posedge sys_clk);
		apb(1'b0, `CS_OFF_STATUS, 32'h0);
		check(rd[16:9], cal_seq_pkg::st_bg_sleep);
		wr_reg(`CS_OFF_CTRL, 32'h00F);
		wr_reg(`CS_OFF_CTRL, 32'h00E);
		check(core_ctl.power, 3'h7);
		stop_test();
	end
endmodule // adc_calibration_sequencer_tb
